/* spi_master_model.sv */
// Behavioural model of the external serial master driving clock and select
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  output logic      sck,
  output logic      mosi,
  output logic      select_n,
  input  wire logic miso,
  input  wire logic miso_oe
);
  logic pol;
  logic pha;

  initial begin
    pol = 1'b0;
    pha = 1'b0;
    sck = 1'b0;
    mosi = 1'b0;
    select_n = 1'b1;
  end

  // Clock parks at the polarity level; only called while the slave is disabled
  task automatic set_mode(input logic p, input logic h);
    pol = p;
    pha = h;
    sck = p;
  endtask

  task automatic set_select(input logic v);
    select_n = v;
  endtask

  // One byte at 48 ns per bit, most significant bit first each way;
  // MISO is taken just ahead of each capture edge, as a real master would
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input logic hold);
    if (!hold) begin
      select_n = 1'b0;
    end
    // Slave needs a few CPU clocks to see select and drive MISO
    #48;
    for (int i = 7; i >= 0; i--) begin
      if (!pha) begin
        mosi = tx[i];
      end
      #24;
      if (!pha) begin
        rx[i] = miso_oe ? miso : 1'bx;
      end
      sck = ~pol;
      if (pha) begin
        mosi = tx[i];
      end
      #24;
      if (pha) begin
        rx[i] = miso_oe ? miso : 1'bx;
      end
      sck = pol;
    end
    // Select must not move in the time step of the last capture edge
    #24;
    // Released data line must not keep showing the last bit
    mosi = ~mosi;
    if (!hold) begin
      select_n = 1'b1;
      #48;
    end
  endtask
endmodule
`default_nettype wire

/* spi_slave_and_error_logic.sv */
// Serial peripheral slave path, error flags and low-power wake logic
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Data write loads the 8-bit shift register, shifted out on MISO MSB first.
// - A slave transfer starts only with incoming serial clock and MSB on MOSI.
// - Byte end sets transfer-complete flag; interrupt if enabled and CPU mask clear.
// - Transfer-complete clears by status access while set, then data read or write.
// - While transfer-complete is set, data writes ignored until status is read.
// - Polarity and phase pick the capture edge; both ends use the same mode.
// - Select low while master sets mode fault and requests an interrupt if enabled.
// - Mode fault clears the interface enable and master select bits.
// - Mode fault clears by status read while set, then a control write.
// - While mode fault is set, enable and master bits refuse to set outside clearing.
// - A slave never sets mode fault, though the flag may stay set.
// - Byte completing while transfer-complete still set sets overrun, interrupt if enabled.
// - After overrun the buffer keeps the first byte after the last clear.
// - Overrun clears when software reads the status register.
// - Data write during a transfer is discarded and sets write collision.
// - Write collision never raises an interrupt.
// - In wait the interface runs normally and its events wake the CPU.
// - In halt registers hold; several bytes give overrun; transfer-complete may wake.
// - Wake from halt only if internal select was low when halt began.
// - Phase 0 captures on the first clock transition, phase 1 on the second.
// - With software select management the internal select follows the level bit.
// - One interrupt request whenever transfer-complete, mode fault or overrun is set.

module spi_slave_and_error_logic (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire spi_slave_pkg::cpu_access_type cpu_access,
  input  wire logic                        cpu_int_mask,
  input  wire logic                        wait_mode,
  input  wire logic                        halt_mode,
  input  wire logic                        sck,
  input  wire logic                        mosi,
  input  wire logic                        select_n_pin,
  output var  spi_slave_pkg::ctrl_type     ctrl_reg,
  output var  spi_slave_pkg::status_type   ctrl_status_reg,
  output logic [7:0]                       data_io_reg,
  output logic                             irq,
  output logic                             wake,
  output logic                             miso_out,
  output logic                             miso_oe
);
  import spi_slave_pkg::*;

  // ************************************************************
  // CPU side: synchronisers and access qualification
  // ************************************************************
  logic [1:0]     ss_sync;
  logic [1:0]     busy_sync;
  logic [2:0]     done_sync;
  logic           select_low;
  logic           byte_done;
  logic           busy;
  logic           mode_fault_event;
  logic           done_seen;
  logic           done_read;
  logic           write_collision_flag_seen;
  logic           mode_fault_flag_seen;
  logic           halt_prev;
  logic           wake_ok;
  logic           link_enable;
  logic           link_rst;
  logic           write_ok;
  logic [7:0]     tx_byte;
  cpu_access_type acc;

  // Link side state
  logic       link_clk;
  logic       link_clear;
  logic [2:0] bit_cnt;
  logic [6:0] rx_shift;
  logic [7:0] rx_hold;
  logic       done_tog;
  logic       busy_link;
  logic       miso_shift;
  logic       launch_seen;

  always_ff @(posedge clock) begin
    if (rst) begin
      ss_sync   <= 2'h3;
      busy_sync <= 2'h0;
      done_sync <= 3'h0;
    end else begin
      ss_sync   <= {ss_sync[0], select_n_pin};
      busy_sync <= {busy_sync[0], busy_link};
      done_sync <= {done_sync[1:0], done_tog};
    end
  end

  // Active low select, from pin or from software
  assign select_low = ctrl_status_reg.sw_select_manage ?
                      !ctrl_status_reg.sw_select_level : !ss_sync[1];
  assign byte_done  = done_sync[2] ^ done_sync[1];
  assign busy       = busy_sync[1];
  // Software cannot reach registers in halt: its accesses are dropped
  assign acc        = halt_mode ? '0 : cpu_access;
  assign mode_fault_event = ctrl_reg.master_select && select_low;
  assign write_ok   = acc.data_write && !busy &&
                      !(ctrl_status_reg.xfer_done_flag && !done_read);

  // ************************************************************
  // Control register
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg <= ctrl_type'(CTRL_RESET);
    end else if (mode_fault_event) begin
      ctrl_reg.iface_enable  <= 1'b0;
      ctrl_reg.master_select <= 1'b0;
    end else if (acc.ctrl_write) begin
      ctrl_reg <= ctrl_type'(acc.wdata);
      if (ctrl_status_reg.mode_fault_flag && !mode_fault_flag_seen) begin
        ctrl_reg.iface_enable  <= 1'b0;
        ctrl_reg.master_select <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Status flags; a hardware set always wins over a clear
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_status_reg <= status_type'(STATUS_RESET);
    end else begin
      if (acc.status_write) begin
        ctrl_status_reg.output_disable   <= acc.wdata[2];
        ctrl_status_reg.sw_select_manage <= acc.wdata[1];
        ctrl_status_reg.sw_select_level  <= acc.wdata[0];
      end
      if (byte_done) begin
        ctrl_status_reg.xfer_done_flag <= 1'b1;
      end else if (done_seen && (acc.data_read || acc.data_write)) begin
        ctrl_status_reg.xfer_done_flag <= 1'b0;
      end
      if (byte_done && ctrl_status_reg.xfer_done_flag) begin
        ctrl_status_reg.overrun_flag <= 1'b1;
      end else if (acc.status_read) begin
        ctrl_status_reg.overrun_flag <= 1'b0;
      end
      if (acc.data_write && busy) begin
        ctrl_status_reg.write_collision_flag <= 1'b1;
      end else if (write_collision_flag_seen && (acc.data_read || acc.data_write)) begin
        ctrl_status_reg.write_collision_flag <= 1'b0;
      end
      if (mode_fault_event) begin
        ctrl_status_reg.mode_fault_flag <= 1'b1;
      end else if (mode_fault_flag_seen && acc.ctrl_write) begin
        ctrl_status_reg.mode_fault_flag <= 1'b0;
      end
    end
  end

  // Clearing sequences: first step remembered until the flag drops
  always_ff @(posedge clock) begin
    if (rst || !ctrl_status_reg.xfer_done_flag) begin
      done_seen <= 1'b0;
      done_read <= 1'b0;
    end else begin
      if (acc.status_read || acc.status_write) begin
        done_seen <= 1'b1;
      end
      if (acc.status_read) begin
        done_read <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst || !ctrl_status_reg.write_collision_flag) begin
      write_collision_flag_seen <= 1'b0;
    end else if (acc.status_read || acc.status_write) begin
      write_collision_flag_seen <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || !ctrl_status_reg.mode_fault_flag) begin
      mode_fault_flag_seen <= 1'b0;
    end else if (acc.status_read) begin
      mode_fault_flag_seen <= 1'b1;
    end
  end

  // ************************************************************
  // Transmit byte and receive buffer
  // ************************************************************
  // Held still while busy, so the link side reads it without a handshake
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_byte <= DATA_RESET;
    end else if (write_ok) begin
      tx_byte <= acc.wdata;
    end
  end

  // Only the first byte after a clear reaches the buffer
  always_ff @(posedge clock) begin
    if (rst) begin
      data_io_reg <= DATA_RESET;
    end else if (byte_done && !ctrl_status_reg.xfer_done_flag) begin
      data_io_reg <= rx_hold;
    end
  end

  // ************************************************************
  // Interrupt, wake and low-power control
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= ctrl_reg.irq_enable && !cpu_int_mask &&
             (ctrl_status_reg.xfer_done_flag || ctrl_status_reg.overrun_flag ||
              ctrl_status_reg.mode_fault_flag);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      halt_prev <= 1'b0;
      wake_ok   <= 1'b0;
    end else begin
      halt_prev <= halt_mode;
      if (halt_mode && !halt_prev) begin
        wake_ok <= select_low;
      end
    end
  end

  // Only transfer-complete can end halt; all three events end wait
  always_ff @(posedge clock) begin
    if (rst) begin
      wake <= 1'b0;
    end else begin
      wake <= ctrl_reg.irq_enable &&
              ((wait_mode && (ctrl_status_reg.xfer_done_flag ||
                ctrl_status_reg.overrun_flag || ctrl_status_reg.mode_fault_flag)) ||
               (halt_mode && wake_ok && ctrl_status_reg.xfer_done_flag));
    end
  end

  // Link runs only as enabled slave, and not in a halt it cannot wake from
  always_ff @(posedge clock) begin
    if (rst) begin
      link_enable <= 1'b0;
      link_rst    <= 1'b1;
      miso_oe     <= 1'b0;
    end else begin
      link_enable <= ctrl_reg.iface_enable && !ctrl_reg.master_select &&
                     !(halt_mode && !(halt_prev ? wake_ok : select_low));
      link_rst    <= 1'b0;
      miso_oe     <= link_enable && select_low && !ctrl_status_reg.output_disable;
    end
  end

  // ************************************************************
  // Link side, clocked by the serial clock
  // ************************************************************
  // Modes 0 and 3 capture on the rising edge, 1 and 2 on the falling one.
  // Polarity and phase must stay still while the clock runs.
  assign link_clk   = sck ^ (ctrl_reg.clk_polarity ^ ctrl_reg.clk_phase);
  // Deselect restarts the bit count; phase 0 relies on select pulsing high
  assign link_clear = !link_enable || (ctrl_status_reg.sw_select_manage ?
                      ctrl_status_reg.sw_select_level : select_n_pin);

  // Async clear keeps the count aligned to select; a select glitch restarts the byte
  always_ff @(posedge link_clk or posedge link_clear) begin
    if (link_clear) begin
      bit_cnt   <= FIRST_BIT;
      rx_shift  <= 7'h00;
      busy_link <= 1'b0;
    end else begin
      rx_shift  <= {rx_shift[5:0], mosi};
      bit_cnt   <= bit_cnt + 3'h1;
      busy_link <= (bit_cnt != LAST_BIT);
    end
  end

  // Byte hand-over: word held stable while the toggle crosses
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      rx_hold  <= DATA_RESET;
      done_tog <= 1'b0;
    end else if (!link_clear && bit_cnt == LAST_BIT) begin
      rx_hold  <= {rx_shift, mosi};
      done_tog <= !done_tog;
    end
  end

  // Launch edge is opposite the capture edge
  always_ff @(negedge link_clk or posedge link_clear) begin
    if (link_clear) begin
      miso_shift  <= 1'b0;
      launch_seen <= 1'b0;
    end else begin
      miso_shift  <= tx_byte[3'(LAST_BIT - bit_cnt)];
      launch_seen <= 1'b1;
    end
  end

  // Phase 0 shows the first bit until the first launch edge, not the first capture
  assign miso_out = (!ctrl_reg.clk_phase && !launch_seen) ?
                    tx_byte[LAST_BIT] : miso_shift;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_done_sets: assert property (byte_done |=> ctrl_status_reg.xfer_done_flag)
    else $error("transfer-complete not set after byte");
  a_done_holds: assert property (ctrl_status_reg.xfer_done_flag && !done_seen
    |=> ctrl_status_reg.xfer_done_flag)
    else $error("transfer-complete cleared without status access");
  a_done_clears: assert property (done_seen && !byte_done
    && (acc.data_read || acc.data_write) |=> !ctrl_status_reg.xfer_done_flag)
    else $error("transfer-complete not cleared by data access");
  a_done_irq: assert property (ctrl_reg.irq_enable && !cpu_int_mask
    && ctrl_status_reg.xfer_done_flag |=> irq)
    else $error("interrupt missing after transfer-complete");
  a_write_blocked: assert property (ctrl_status_reg.xfer_done_flag && !done_read
    && acc.data_write |=> $stable(tx_byte))
    else $error("data write accepted before status read");
  a_fault_effects: assert property (mode_fault_event
    |=> ctrl_status_reg.mode_fault_flag && !ctrl_reg.iface_enable && !ctrl_reg.master_select)
    else $error("mode fault did not set flag and drop enables");
  a_fault_refuse: assert property (ctrl_status_reg.mode_fault_flag && !mode_fault_flag_seen
    && acc.ctrl_write |=> !ctrl_reg.iface_enable && !ctrl_reg.master_select)
    else $error("enable set during mode fault");
  a_fault_clear: assert property (mode_fault_flag_seen && acc.ctrl_write && !mode_fault_event
    |=> !ctrl_status_reg.mode_fault_flag)
    else $error("mode fault not cleared by control write");
  a_slave_no_fault: assert property (!ctrl_reg.master_select
    |=> !$rose(ctrl_status_reg.mode_fault_flag))
    else $error("mode fault set in slave mode");
  a_overrun_sets: assert property (byte_done && ctrl_status_reg.xfer_done_flag
    |=> ctrl_status_reg.overrun_flag && $stable(data_io_reg))
    else $error("overrun not flagged or buffer overwritten");
  a_overrun_clear: assert property (acc.status_read && !byte_done
    |=> !ctrl_status_reg.overrun_flag)
    else $error("overrun not cleared by status read");
  a_collision_set: assert property (acc.data_write && busy
    |=> ctrl_status_reg.write_collision_flag && $stable(tx_byte))
    else $error("collision not flagged or write taken");
  a_collision_quiet: assert property ($rose(ctrl_status_reg.write_collision_flag)
    && !ctrl_status_reg.xfer_done_flag && !ctrl_status_reg.overrun_flag
    && !ctrl_status_reg.mode_fault_flag |=> !irq)
    else $error("collision raised an interrupt");
  a_irq_raise: assert property (ctrl_reg.irq_enable && !cpu_int_mask
    && ctrl_status_reg.mode_fault_flag |=> irq)
    else $error("interrupt missing for set flag");
  a_halt_wake: assert property (halt_mode && wake_ok && ctrl_reg.irq_enable
    && ctrl_status_reg.xfer_done_flag |=> wake)
    else $error("no wake from halt on transfer-complete");
  a_wait_wake: assert property (ctrl_reg.irq_enable && wait_mode
    && ctrl_status_reg.xfer_done_flag |=> wake)
    else $error("no wake from wait on transfer-complete");

  c_byte_done: cover property (byte_done);
  c_overrun:   cover property ($rose(ctrl_status_reg.overrun_flag));
  c_mode_fault: cover property ($rose(ctrl_status_reg.mode_fault_flag));
  c_collision: cover property ($rose(ctrl_status_reg.write_collision_flag));
  c_halt_wake: cover property (halt_mode && wake);

endmodule
`default_nettype wire

/* spi_slave_and_error_logic_tb.sv */
// Self-checking testbench for the serial peripheral slave block
`timescale 1ns/1ps
`default_nettype none
module spi_slave_and_error_logic_tb;
  import spi_slave_pkg::*;
  localparam logic [4:0] CW = 5'h10;
  localparam logic [4:0] SR = 5'h08;
  localparam logic [4:0] SW = 5'h04;
  localparam logic [4:0] DR = 5'h02;
  localparam logic [4:0] DW = 5'h01;

  logic           clock;
  logic           rst;
  cpu_access_type acc;
  logic           cpu_int_mask;
  logic           wait_mode;
  logic           halt_mode;
  wire logic      sck;
  wire logic      mosi;
  wire logic      select_n_pin;
  ctrl_type       ctrl_reg;
  status_type     ctrl_status_reg;
  logic [7:0]     data_io_reg;
  logic           irq;
  logic           wake;
  logic           miso_out;
  logic           miso_oe;
  logic [7:0]     rx;
  logic [1:0]     md;
  int             err_count;
  int             checks_done;

  spi_slave_and_error_logic u_dut (
    .clock(clock), .rst(rst), .cpu_access(acc), .cpu_int_mask(cpu_int_mask),
    .wait_mode(wait_mode), .halt_mode(halt_mode), .sck(sck), .mosi(mosi),
    .select_n_pin(select_n_pin), .ctrl_reg(ctrl_reg), .ctrl_status_reg(ctrl_status_reg),
    .data_io_reg(data_io_reg), .irq(irq), .wake(wake), .miso_out(miso_out),
    .miso_oe(miso_oe)
  );

  spi_master_model u_master (
    .sck(sck), .mosi(mosi), .select_n(select_n_pin), .miso(miso_out), .miso_oe(miso_oe)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One-cycle strobe, then a quiet cycle so strobes never collide
  task automatic cpu(input logic [4:0] s, input logic [7:0] d);
    acc = cpu_access_type'({s, d});
    @(negedge clock);
    acc = '0;
    @(negedge clock);
  endtask

  task automatic wait_done();
    for (int i = 0; i < 20 && ctrl_status_reg.xfer_done_flag !== 1'b1; i++) begin
      @(negedge clock);
    end
    repeat (2) @(negedge clock);
    check(ctrl_status_reg.xfer_done_flag, 1'b1);
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    err_count = 0;
    checks_done = 0;
    rst = 1'b1;
    acc = '0;
    cpu_int_mask = 1'b0;
    wait_mode = 1'b0;
    halt_mode = 1'b0;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    check(ctrl_reg, CTRL_RESET);
    check(ctrl_status_reg, STATUS_RESET);
    check({5'h00, irq, wake, miso_oe}, 8'h00);
    // All four clock modes, mask toggled on odd phases
    for (int m = 0; m < 4; m++) begin
      md = 2'(m);
      cpu(CW, 8'h00);
      u_master.set_mode(md[1], md[0]);
      cpu_int_mask = md[0];
      cpu(CW, 8'hc0 | {4'h0, md, 2'b00});
      cpu(DW, 8'ha5 ^ {6'h00, md});
      u_master.xfer(8'h69 + {6'h00, md}, rx, 1'b0);
      check(rx, 8'ha5 ^ {6'h00, md});
      wait_done();
      check(data_io_reg, 8'h69 + {6'h00, md});
      check(irq, !cpu_int_mask);
      check(ctrl_status_reg.mode_fault_flag, 1'b0);
      cpu(SR, 8'h00);
      cpu(DR, 8'h00);
      check(ctrl_status_reg.xfer_done_flag, 1'b0);
    end
    cpu_int_mask = 1'b0;
    // Phase 1, select held low; write while done-flag set is dropped
    u_master.set_select(1'b0);
    u_master.xfer(8'h81, rx, 1'b1);
    check(rx, 8'ha6);
    wait_done();
    cpu(DW, 8'h3c);
    cpu(SR, 8'h00);
    cpu(DR, 8'h00);
    u_master.xfer(8'h42, rx, 1'b1);
    check(rx, 8'ha6);
    wait_done();
    check(data_io_reg, 8'h42);
    cpu(SR, 8'h00);
    cpu(DR, 8'h00);
    u_master.set_select(1'b1);
    // Write collision in mid-byte
    cpu(CW, 8'h00);
    u_master.set_mode(1'b0, 1'b0);
    cpu(CW, 8'hc0);
    cpu(DW, 8'h33);
    fork
      u_master.xfer(8'h77, rx, 1'b0);
      begin
        repeat (20) @(negedge clock);
        cpu(DW, 8'h55);
        check(ctrl_status_reg.write_collision_flag, 1'b1);
        check(irq, 1'b0);
      end
    join
    check(rx, 8'h33);
    wait_done();
    check(data_io_reg, 8'h77);
    cpu(SR, 8'h00);
    cpu(DR, 8'h00);
    check(ctrl_status_reg[7:6], 8'h00);
    // Overrun: second byte while done-flag still set
    u_master.xfer(8'ha1, rx, 1'b0);
    u_master.xfer(8'hb2, rx, 1'b0);
    repeat (10) @(negedge clock);
    check(ctrl_status_reg.overrun_flag, 1'b1);
    check(data_io_reg, 8'ha1);
    check(irq, 1'b1);
    cpu(SR, 8'h00);
    check(ctrl_status_reg.overrun_flag, 1'b0);
    cpu(DR, 8'h00);
    // Software select, wait and halt
    cpu(CW, 8'h00);
    u_master.set_mode(1'b1, 1'b1);
    cpu(CW, 8'hcc);
    cpu(SW, 8'h02);
    wait_mode = 1'b1;
    u_master.xfer(8'hc3, rx, 1'b1);
    wait_done();
    check(data_io_reg, 8'hc3);
    check(wake, 1'b1);
    cpu(SR, 8'h00);
    cpu(DR, 8'h00);
    wait_mode = 1'b0;
    halt_mode = 1'b1;
    u_master.xfer(8'h5e, rx, 1'b1);
    u_master.xfer(8'he7, rx, 1'b1);
    repeat (10) @(negedge clock);
    check(wake, 1'b1);
    halt_mode = 1'b0;
    @(negedge clock);
    check(ctrl_status_reg, 8'ha2);
    check(data_io_reg, 8'h5e);
    cpu(SR, 8'h00);
    cpu(DR, 8'h00);
    check(miso_oe, 1'b1);
    cpu(SW, 8'h06);
    check(miso_oe, 1'b0);
    // Mode fault while master
    cpu(SW, 8'h03);
    cpu(CW, 8'hd0);
    check(ctrl_reg, 8'hd0);
    cpu(SW, 8'h02);
    repeat (3) @(negedge clock);
    check(ctrl_status_reg.mode_fault_flag, 1'b1);
    check(ctrl_reg, 8'h80);
    check({irq, miso_oe}, 8'h02);
    cpu(SW, 8'h03);
    cpu(CW, 8'hd0);
    check(ctrl_reg, 8'h80);
    cpu(SR, 8'h00);
    cpu(CW, 8'hd0);
    check(ctrl_reg, 8'hd0);
    check(ctrl_status_reg.mode_fault_flag, 1'b0);
    cpu(CW, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire

/* spi_slave_pkg.sv */
// Shared constants and carriers for the serial peripheral slave block
package spi_slave_pkg;

  localparam int         DATA_WIDTH   = 8;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET   = 8'h00;
  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam logic [2:0] FIRST_BIT    = 3'h0;

  // Control word, most significant field first
  typedef struct packed {
    logic       irq_enable;
    logic       iface_enable;
    logic       divider_sel;
    logic       master_select;
    logic       clk_polarity;
    logic       clk_phase;
    logic [1:0] rate_sel;
  } ctrl_type;

  // Control/status word, most significant field first
  typedef struct packed {
    logic xfer_done_flag;
    logic write_collision_flag;
    logic overrun_flag;
    logic mode_fault_flag;
    logic reserved;
    logic output_disable;
    logic sw_select_manage;
    logic sw_select_level;
  } status_type;

  // One cycle of software access; strobes are one-cycle pulses
  typedef struct packed {
    logic       ctrl_write;
    logic       status_read;
    logic       status_write;
    logic       data_read;
    logic       data_write;
    logic [7:0] wdata;
  } cpu_access_type;

endpackage
